// *** pkg/panel_regs.svh ***
// Register offsets, field positions, reset values and timing counts.
// Assumes 32-bit APB, word-aligned offsets.
`ifndef PANEL_REGS_SVH
`define PANEL_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFF_CTRL        12'h000
`define OFF_EXPECT      12'h004
`define OFF_STATUS      12'h008
`define OFF_CODE        12'h00C
`define OFF_LOG         12'h010

// ****************************************
// Field positions
// ****************************************
`define CTRL_LATCH_CLR  0
`define CTRL_OFF_DONE   1
`define CTRL_LOG_IDX_LO 4
`define CTRL_LOG_IDX_HI 6
`define ST_MODE_LO      0
`define ST_MODE_HI      2
`define ST_FAULT        4
`define ST_LATCH        5
`define ST_SAFE         6
`define ST_WINDOW       7
`define ST_AUTO         8

// ****************************************
// Reset values and codes
// ****************************************
`define EXPECT_RST      16'h0000
`define CODE_NONE       8'h00
`define CODE_SLOT       8'hE1
`define RO_OFFLINE      8'hC0
`define SAFE_OUT        8'h00
`define SEV_HI          7
`define SEV_LO          5

// ****************************************
// Timing
// ****************************************
`define CLK_HZ          10000000
`define ENTRY_WINDOW_S  20
`define STARTUP_US      100
`define STARTUP_CYCLES  ((`STARTUP_US * `CLK_HZ) / 1000000)

`endif

// *** pkg/panel_pkg.sv ***
// Types shared by the faceplate supervision logic.
// Assumes panel_regs.svh supplies the numeric constants.
package panel_pkg;

  typedef enum logic [2:0] {
    mode_startup = 3'b000,
    mode_run     = 3'b001,
    mode_safe    = 3'b010,
    mode_offline = 3'b011,
    halted_fault_mode = 3'b100
  } mode_e;

  typedef enum logic [1:0] {
    seq_idle = 2'b00,
    seq_one  = 2'b01,
    seq_two  = 2'b10
  } seq_e;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } diag_s;

  typedef struct packed {
    logic       run_led;
    logic       fault_led;
    logic [7:0] readout;
  } face_s;

endpackage : panel_pkg

// *** hw/module_fault_status_panel.sv ***
// Faceplate indicators, fault readout, power-up entry window and
// safe-state supervision of one chassis module.
// Assumes pins arrive asynchronously and diagnostics run on pclk.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "panel_regs.svh"

module module_fault_status_panel #(
  parameter int unsigned ENTRY_WINDOW_CYCLES = `ENTRY_WINDOW_S * `CLK_HZ
) (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB
  input  wire panel_pkg::apb_req_s apb_req,
  output panel_pkg::apb_rsp_s      apb_rsp,
  // Faceplate
  input  wire logic                button_up_pin,
  input  wire logic                button_sel_pin,
  output panel_pkg::face_s         face,
  // Diagnostics and backplane
  input  wire panel_pkg::diag_s    diag,
  input  wire logic [3:0]          io_present_pin,
  input  wire logic [15:0]         slot_id_pin,
  input  wire logic                override_set_pin,
  input  wire logic                auto_release_pin,
  input  wire logic                tuning_access_pin,
  // Outputs to field and links
  input  wire logic [7:0]          app_out,
  output logic [7:0]               field_out,
  output logic                     outputs_safe,
  output logic                     tuning_link_enable,
  output logic                     maint_tx_enable,
  output logic                     maint_rx_enable
);
  import panel_pkg::*;

  localparam int unsigned WIN_W = $clog2(ENTRY_WINDOW_CYCLES + 1);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    mode_e                 mode;
    logic [1:0]            up_s;
    logic [1:0]            sel_s;
    logic                  up_q;
    logic                  sel_q;
    logic [1:0][3:0]       pres_s;
    logic [1:0][15:0]      slot_s;
    logic [1:0]            ovr_s;
    logic [1:0]            auto_s;
    logic [1:0]            tune_s;
    logic                  auto_cfg;
    logic                  auto_taken;
    logic [WIN_W-1:0]      win_cnt;
    logic                  win_open;
    logic [15:0]           start_cnt;
    seq_e                  seq;
    logic                  safety_override_latch;
    logic                  fault_led;
    logic [7:0]            disp_code;
    logic [7:0][7:0]       log;
    logic [2:0]            log_wr;
    logic [2:0]            menu_idx;
    logic                  menu_view;
    logic [2:0]            log_sel;
    logic [15:0]           expect_slots;
    logic [31:0]           prdata;
    logic                  pslverr;
    logic [7:0]            field_out;
    logic                  outputs_safe;
    logic                  run_led;
    logic [7:0]            readout;
    logic                  tune_en;
  } state_s;

  state_s r;
  state_s next_r;

  function automatic logic [2:0] severity(input logic [7:0] code);
    severity = code[`SEV_HI:`SEV_LO];
  endfunction : severity

  function automatic logic outranks(input logic [7:0] code, input logic [7:0] shown);
    outranks = (shown == `CODE_NONE) || (severity(code) > severity(shown));
  endfunction : outranks

  // ****************************************
  // Next state
  // ****************************************
  logic       up_press;
  logic       sel_press;
  logic       buttons_live;
  logic       removed;
  logic       wr_acc;
  logic       rd_setup;
  logic [7:0] new_code;
  logic       new_fault;

  always_comb begin
    next_r = r;
    // Two-stage pin synchronisers
    next_r.up_s   = {r.up_s[0], button_up_pin};
    next_r.sel_s  = {r.sel_s[0], button_sel_pin};
    next_r.pres_s = {r.pres_s[0], io_present_pin};
    next_r.slot_s = {r.slot_s[0], slot_id_pin};
    next_r.ovr_s  = {r.ovr_s[0], override_set_pin};
    next_r.auto_s = {r.auto_s[0], auto_release_pin};
    next_r.tune_s = {r.tune_s[0], tuning_access_pin};
    next_r.up_q   = r.up_s[1];
    next_r.sel_q  = r.sel_s[1];
    up_press      = r.up_s[1] & ~r.up_q;
    sel_press     = r.sel_s[1] & ~r.sel_q;

    // Strap caught once, after its synchroniser has filled
    // Earlier the second stage still holds its reset value
    if (!r.auto_taken && r.start_cnt == 16'd2) begin
      next_r.auto_taken = 1'b1;
      next_r.auto_cfg   = r.auto_s[1];
    end

    if (r.win_open) begin
      if (r.win_cnt == WIN_W'(ENTRY_WINDOW_CYCLES - 1)) begin
        next_r.win_open = 1'b0;
      end else begin
        next_r.win_cnt = r.win_cnt + WIN_W'(1);
      end
    end

    // Buttons read only in window or offline
    buttons_live = r.win_open || (r.mode == mode_offline);

    // Sequence up, up, select enters offline
    if (r.win_open && r.mode != mode_offline && r.mode != halted_fault_mode) begin
      case (r.seq)
        seq_idle: next_r.seq = up_press ? seq_one : seq_idle;
        seq_one:  next_r.seq = up_press ? seq_two : (sel_press ? seq_idle : seq_one);
        seq_two: begin
          if (sel_press) begin
            next_r.mode = mode_offline;
            next_r.seq  = seq_idle;
          end else if (up_press) begin
            next_r.seq = seq_idle;
          end
        end
        default: next_r.seq = seq_idle;
      endcase
    end

    // Menu: select toggles view, up scrolls log
    if (buttons_live && r.mode != mode_startup) begin
      if (sel_press && r.seq == seq_idle) begin
        next_r.menu_view = ~r.menu_view;
      end
      if (up_press && r.menu_view) begin
        next_r.menu_idx = r.menu_idx + 3'd1;
      end
    end

    if (r.ovr_s[1]) begin
      next_r.safety_override_latch = 1'b1;
    end

    new_code  = diag.code;
    new_fault = diag.valid;
    if (r.mode == mode_startup) begin
      if (r.start_cnt == 16'(`STARTUP_CYCLES - 1)) begin
        if (r.slot_s[1] != r.expect_slots) begin
          next_r.mode = halted_fault_mode;
          new_code    = `CODE_SLOT;
          new_fault   = 1'b1;
        end else if (r.safety_override_latch && !r.auto_cfg) begin
          next_r.mode = mode_safe;
        end else begin
          next_r.mode                  = mode_run;
          // Pin still high keeps the latch: set wins
          next_r.safety_override_latch = r.ovr_s[1];
        end
      end else begin
        next_r.start_cnt = r.start_cnt + 16'd1;
      end
    end

    // Self-diagnostic faults and the startup slot mismatch reach the indicator
    if (new_fault) begin
      next_r.fault_led          = 1'b1;
      next_r.log[r.log_wr]      = new_code;
      next_r.log_wr             = r.log_wr + 3'd1;
      // Strictly more severe replaces shown code
      if (outranks(new_code, r.disp_code)) begin
        next_r.disp_code = new_code;
      end
    end

    // ****************************************
    // APB slave, zero wait states
    // ****************************************
    wr_acc   = apb_req.psel && apb_req.penable && apb_req.pwrite;
    rd_setup = apb_req.psel && !apb_req.penable;
    if (rd_setup) begin
      next_r.pslverr = 1'b0;
      next_r.prdata  = 32'h0000_0000;
      case (apb_req.paddr)
        `OFF_CTRL:   next_r.prdata[`CTRL_LOG_IDX_HI:`CTRL_LOG_IDX_LO] = r.log_sel;
        `OFF_EXPECT: next_r.prdata[15:0] = r.expect_slots;
        `OFF_STATUS: begin
          next_r.prdata[`ST_MODE_HI:`ST_MODE_LO] = r.mode;
          next_r.prdata[`ST_FAULT]  = r.fault_led;
          next_r.prdata[`ST_LATCH]  = r.safety_override_latch;
          next_r.prdata[`ST_SAFE]   = r.outputs_safe;
          next_r.prdata[`ST_WINDOW] = r.win_open;
          next_r.prdata[`ST_AUTO]   = r.auto_cfg;
        end
        `OFF_CODE:   next_r.prdata[7:0] = r.disp_code;
        `OFF_LOG:    next_r.prdata[7:0] = r.log[r.log_sel];
        default:     next_r.pslverr = 1'b1;
      endcase
    end
    if (wr_acc) begin
      case (apb_req.paddr)
        `OFF_CTRL: begin
          next_r.log_sel = apb_req.pwdata[`CTRL_LOG_IDX_HI:`CTRL_LOG_IDX_LO];
          if (apb_req.pwdata[`CTRL_LATCH_CLR] && !r.ovr_s[1]) begin
            next_r.safety_override_latch = 1'b0;
            if (r.mode == mode_safe) begin
              next_r.mode = mode_run;
            end
          end
          // Offline work done: restart through startup
          if (apb_req.pwdata[`CTRL_OFF_DONE] && r.mode == mode_offline) begin
            next_r.mode      = mode_startup;
            next_r.start_cnt = 16'd0;
          end
        end
        `OFF_EXPECT: begin
          if (r.mode == mode_startup) begin
            next_r.expect_slots = apb_req.pwdata[15:0];
          end
        end
        default: ;
      endcase
    end

    // Latch set at run time drops to held safe
    // Same cycle as the latch, so RUN never shows with outputs safe
    if (next_r.mode == mode_run && next_r.safety_override_latch) begin
      next_r.mode = mode_safe;
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Any module missing forces safe
    removed = (r.pres_s[1] != 4'hF);
    // Override, offline, fault or startup are safe
    next_r.outputs_safe = removed || (next_r.mode != mode_run) ||
                          next_r.safety_override_latch;
    next_r.field_out    = next_r.outputs_safe ? `SAFE_OUT : app_out;
    next_r.run_led      = (next_r.mode == mode_run) && !removed;
    // Offline status, log view, shown code or mode
    if (next_r.mode == mode_offline) begin
      next_r.readout = `RO_OFFLINE | {5'h00, next_r.seq, 1'b0};
    end else if (next_r.menu_view) begin
      next_r.readout = next_r.log[next_r.menu_idx];
    end else if (next_r.disp_code != `CODE_NONE) begin
      next_r.readout = next_r.disp_code;
    end else begin
      next_r.readout = {5'h00, next_r.mode};
    end
    // Tuning port powered only with access
    next_r.tune_en = r.tune_s[1];
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r                       <= '0;
      r.mode                  <= mode_startup;
      r.seq                   <= seq_idle;
      r.win_open              <= 1'b1;
      r.safety_override_latch <= 1'b1;
      r.expect_slots          <= `EXPECT_RST;
      r.outputs_safe          <= 1'b1;
      r.field_out             <= `SAFE_OUT;
      r.disp_code             <= `CODE_NONE;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Port drive
  // ****************************************
  assign apb_rsp.prdata  = r.prdata;
  // No wait states: every access completes at once
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = r.pslverr && apb_req.psel && apb_req.penable;
  assign face.run_led    = r.run_led;
  assign face.fault_led  = r.fault_led;
  assign face.readout    = r.readout;
  assign field_out       = r.field_out;
  assign outputs_safe    = r.outputs_safe;
  assign tuning_link_enable = r.tune_en;
  assign maint_tx_enable = r.run_led;
  assign maint_rx_enable = 1'b0;

endmodule : module_fault_status_panel

// *** sim/panel_monitor.sv ***
// Concurrent checks on the faceplate supervision ports.
// Assumes it is bound onto module_fault_status_panel.
`timescale 1ns/100ps
`include "panel_regs.svh"
module panel_monitor (
  // Clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // Observed ports
  input wire panel_pkg::face_s    face,
  input wire panel_pkg::diag_s    diag,
  input wire logic [3:0]          io_present_pin,
  input wire logic                tuning_access_pin,
  input wire logic [7:0]          field_out,
  input wire logic                outputs_safe,
  input wire logic                tuning_link_enable,
  input wire logic                maint_tx_enable,
  input wire logic                maint_rx_enable
);
  import panel_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // Sequences
  // ****************************************
  sequence s_no_access;
    !tuning_access_pin [*4];
  endsequence
  sequence s_access;
    tuning_access_pin [*4];
  endsequence
  sequence s_io_gone;
    io_present_pin != 4'hF;
  endsequence
  // ****************************************
  // Properties
  // ****************************************
  a_rx_closed: assert property (!maint_rx_enable)
    else $error("maintenance receive enabled");
  a_run_not_safe: assert property (face.run_led |-> !outputs_safe)
    else $error("run lit while outputs forced safe");
  a_fault_sticky: assert property (!$fell(face.fault_led))
    else $error("fault indicator cleared");
  a_diag_lights: assert property (diag.valid && diag.code != `CODE_NONE |=> face.fault_led)
    else $error("fault indicator not lit by diagnostic");
  a_safe_zero: assert property (outputs_safe |-> field_out == `SAFE_OUT)
    else $error("field outputs not safe");
  a_io_safe: assert property (s_io_gone |-> ##[1:4] outputs_safe)
    else $error("missing module left outputs live");
  a_io_run_off: assert property (s_io_gone |-> ##[1:4] !face.run_led)
    else $error("run lit with module missing");
  a_tuning_off: assert property (s_no_access |-> !tuning_link_enable)
    else $error("tuning link live without access");
  a_tuning_on: assert property (s_access |-> tuning_link_enable)
    else $error("tuning link dead with access");
endmodule : panel_monitor

bind module_fault_status_panel panel_monitor i_panel_monitor (
  .pclk(pclk), .presetn(presetn), .face(face), .diag(diag),
  .io_present_pin(io_present_pin), .tuning_access_pin(tuning_access_pin),
  .field_out(field_out), .outputs_safe(outputs_safe),
  .tuning_link_enable(tuning_link_enable), .maint_tx_enable(maint_tx_enable),
  .maint_rx_enable(maint_rx_enable)
);

// *** sim/panel_tech_model.sv ***
// Technician at the faceplate pressing the entry sequence.
// Assumes start is a one-cycle request on pclk.
`timescale 1ns/100ps
module panel_tech_model (
  // Clock and request
  input wire logic pclk,
  input wire logic start,
  // Buttons
  output logic     up,
  output logic     sel,
  output logic     busy
);
  task press(input logic s);
    if (s) sel <= 1'b1;
    else up <= 1'b1;
    repeat (4) @(posedge pclk);
    up  <= 1'b0;
    sel <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : press
  initial begin
    up   = 1'b0;
    sel  = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge pclk);
      if (start) begin
        busy <= 1'b1;
        press(1'b0);
        press(1'b0);
        press(1'b1);
        busy <= 1'b0;
      end
    end
  end
endmodule : panel_tech_model

// *** sim/module_fault_status_panel_tb_top.sv ***
// Self-checking bench for the faceplate supervision block.
// Assumes panel_tech_model on the buttons and the bound monitor.
`timescale 1ns/100ps
`include "panel_regs.svh"
module module_fault_status_panel_tb_top;
  import panel_pkg::*;
  localparam int WIN = 3000;
  logic        pclk, presetn, ovr, tacc, go, busy, up, sel, safe, tlink, tx, rx, err, strap;
  apb_req_s    req;
  apb_rsp_s    rsp;
  face_s       face;
  diag_s       diag;
  logic [3:0]  io;
  logic [15:0] slot;
  logic [7:0]  app, fout, shown, c;
  logic [31:0] q;
  logic [7:0]  codes [8];
  int          failures, comparisons;
  module_fault_status_panel #(.ENTRY_WINDOW_CYCLES(WIN)) i_module_fault_status_panel (
    .pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .button_up_pin(up), .button_sel_pin(sel), .face(face),
    .diag(diag), .io_present_pin(io), .slot_id_pin(slot), .override_set_pin(ovr),
    .auto_release_pin(strap), .tuning_access_pin(tacc), .app_out(app),
    .field_out(fout), .outputs_safe(safe), .tuning_link_enable(tlink),
    .maint_tx_enable(tx), .maint_rx_enable(rx));
  panel_tech_model i_panel_tech_model (.pclk(pclk), .start(go), .up(up), .sel(sel),
    .busy(busy));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ****************************************
  // Helpers
  // ****************************************
  task print_verdict;
    if (failures == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    q   = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    apb(1'b0, `OFF_STATUS, 0);
    while (q[2:0] !== m && n < 2000) begin
      apb(1'b0, `OFF_STATUS, 0);
      n++;
    end
    chk("mode", m, q[2:0]);
  endtask : wait_mode
  task press_seq;
    @(posedge pclk) go <= 1'b1;
    @(posedge pclk) go <= 1'b0;
    @(posedge pclk);
    for (int i = 0; i < 100 && busy; i++) @(posedge pclk);
    repeat (4) @(posedge pclk);
  endtask : press_seq
  task do_reset;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset
  function logic [7:0] keep(input logic [7:0] cur, input logic [7:0] nw);
    return (cur == `CODE_NONE || nw[7:5] > cur[7:5]) ? nw : cur;
  endfunction : keep
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    presetn = 1'b0; ovr = 1'b0; tacc = 1'b0; go = 1'b0; io = 4'hF; app = 8'h00;
    req = '0; diag = '0; failures = 0; comparisons = 0;
    strap = 1'b0;
    void'($urandom(11873));
    slot = 16'($urandom) | 16'h0001;
    do_reset();
    apb(1'b0, `OFF_STATUS, 0);
    chk("status", 32'h0000_00E0, q);
    apb(1'b1, `OFF_EXPECT, {16'h0000, slot});
    press_seq();
    wait_mode(3'd3);
    chk("readout", `RO_OFFLINE, face.readout);
    chk("safe", 1, safe);
    repeat (WIN) @(posedge pclk);
    apb(1'b1, `OFF_CTRL, 32'h0000_0002);
    wait_mode(3'd2);
    press_seq();
    wait_mode(3'd2);
    apb(1'b1, `OFF_CTRL, 32'h0000_0001);
    wait_mode(3'd1);
    chk("run", 1, face.run_led);
    app <= 8'($urandom) | 8'h01;
    repeat (3) @(posedge pclk);
    chk("field", app, fout);
    ovr <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("override", 1, safe);
    apb(1'b1, `OFF_CTRL, 32'h0000_0001);
    wait_mode(3'd2);
    ovr <= 1'b0;
    apb(1'b1, `OFF_CTRL, 32'h0000_0001);
    wait_mode(3'd1);
    io <= 4'b1011;
    repeat (5) @(posedge pclk);
    chk("io safe", 1, safe);
    io <= 4'hF;
    chk("fault", 0, face.fault_led);
    shown = `CODE_NONE;
    for (int i = 0; i < 8; i++) begin
      c = (i == 0) ? 8'hA3 : (i == 1) ? 8'hA7 : (i == 2) ? 8'h41 : 8'($urandom) | 8'h20;
      @(posedge pclk) diag <= '{1'b1, c};
      @(posedge pclk) diag <= '0;
      shown = keep(shown, c);
      codes[i] = c;
      apb(1'b0, `OFF_CODE, 0);
      chk("code", shown, q[7:0]);
      chk("fault", 1, face.fault_led);
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `OFF_CTRL, 32'(i) << `CTRL_LOG_IDX_LO);
      apb(1'b0, `OFF_LOG, 0);
      chk("log", codes[i], q[7:0]);
    end
    tacc <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("tuning", 1, tlink);
    tacc <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("tuning", 0, tlink);
    chk("rx", 0, rx);
    apb(1'b0, 12'h020, 0);
    chk("slverr", 1, err);
    chk("rdata", 0, q);
    strap <= 1'b1;
    do_reset();
    wait_mode(3'd4);
    chk("auto", 1, q[`ST_AUTO]);
    apb(1'b0, `OFF_CODE, 0);
    chk("slot code", `CODE_SLOT, q[7:0]);
    chk("fault", 1, face.fault_led);
    print_verdict();
  end
  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    print_verdict();
  end
endmodule : module_fault_status_panel_tb_top
